// *** sdbg_defs.svh ***
// Timing counts and line-shape constants for the single-wire debug host.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SDBG_DEFS_SVH
`define SDBG_DEFS_SVH

// ============================================================
// Pacing after a command, in bus clock cycles
`define SDBG_HW_RD_WAIT   8'h96
`define SDBG_HW_WR_WAIT   8'h96
`define SDBG_FW_RD_WAIT   8'h30
`define SDBG_FW_WR_WAIT   8'h24
`define SDBG_RUN_WAIT     8'h4c
`define SDBG_STEAL_WAIT   8'h80

// ============================================================
// Line shape, in serial clock cycles
`define SDBG_BIT_LAST     8'h0f
`define SDBG_ONE_LOW      8'h04
`define SDBG_ZERO_LOW     8'h0d
`define SDBG_RX_LOW       8'h02
`define SDBG_RX_SAMPLE    8'h0a
`define SDBG_ABORT_LAST   8'h7f

`endif

// *** sdbg_pkg.sv ***
// Types shared by the single-wire debug host.
// Assumes the constants header is on the include path.
package sdbg_pkg;
  `include "sdbg_defs.svh"

  typedef enum logic [2:0] {
    SDBG_K_HW_RD = 3'b000,
    SDBG_K_HW_WR = 3'b001,
    SDBG_K_FW_RD = 3'b010,
    SDBG_K_FW_WR = 3'b011,
    SDBG_K_RUN   = 3'b100,
    SDBG_K_PLAIN = 3'b101
  } sdbg_kind_t;

  typedef enum logic [3:0] {
    SDBG_S_IDLE     = 4'b0000,
    SDBG_S_TX_BIT   = 4'b0001,
    SDBG_S_PACE     = 4'b0010,
    SDBG_S_ACK_LO   = 4'b0011,
    SDBG_S_ACK_HI   = 4'b0100,
    SDBG_S_RX_BIT   = 4'b0101,
    SDBG_S_ABORT_LO = 4'b0110,
    SDBG_S_ABORT_HI = 4'b0111,
    SDBG_S_SYNC_LO  = 4'b1000,
    SDBG_S_SYNC_HI  = 4'b1001
  } sdbg_state_t;
endpackage

// *** sdbg_tick.sv ***
// Divider that makes a one-cycle tick every DIV system clocks.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sdbg_tick
#(
  parameter int DIV = 4
)
(
  input  wire logic clk_sys,
  input  wire logic srst,
  output logic      tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_tick;

  always_comb
  begin
    next_tick = 1'b0;
    next_cnt  = cnt + 16'h0001;
    if (cnt == 16'(DIV - 1))
    begin
      next_cnt  = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  // ============================================================
  // Checks
  property p_tick_gap;
    @(posedge clk_sys) disable iff (srst)
      tick |-> cnt == 16'h0000;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick not aligned to divider wrap");
endmodule

// *** sdbg_host.sv ***
// Host controller for a single-wire open-drain debug line.
// Assumes a pull-up on the line and a target keeping its own timing.
//
// What this block does
// - Host waits 150 bus cycles after a read address before reading.
// - Host waits 150 bus cycles after write data before next command.
// - Host waits 48 bus cycles after firmware read opcode.
// - Host waits 36 bus cycles after firmware write data.
// - Host waits 76 bus cycles after single step or resume.
// - With unknown bus rate, host waits for acknowledge instead.
// - Eight bit times per byte, each opened by a falling edge.
// - Line driven high only in one-cycle speedup pulses.
// - No new command while an acknowledge is outstanding; abort first.
// - Abort: low 128 serial cycles, then one high speedup cycle.
`timescale 1ns/1ps
`include "sdbg_defs.svh"
module sdbg_host
  import sdbg_pkg::*;
#(
  parameter int SER_DIV = 4,
  parameter int BUS_DIV = 4
)
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        cmd_valid,
  input  wire sdbg_kind_t  cmd_kind,
  input  wire logic        cmd_use_ack,
  input  wire logic [39:0] cmd_tx,
  input  wire logic [2:0]  cmd_tx_bytes,
  input  wire logic [1:0]  cmd_rx_bytes,
  input  wire logic        abort_req,
  output logic             cmd_ready,
  output logic             done,
  output logic [15:0]      rd_data,
  output logic             ack_wait,
  input  wire logic        debug_serial_line_in,
  output logic             debug_serial_line_out,
  output logic             debug_serial_line_oe_n
);
  sdbg_state_t state;
  sdbg_state_t next_state;
  sdbg_kind_t  kind;
  sdbg_kind_t  next_kind;
  logic        use_ack;
  logic        next_use_ack;
  logic [7:0]  scyc;
  logic [7:0]  next_scyc;
  logic [5:0]  bitn;
  logic [5:0]  next_bitn;
  logic [4:0]  rxn;
  logic [4:0]  next_rxn;
  logic [39:0] tx_sh;
  logic [39:0] next_tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] next_rx_sh;
  logic [7:0]  pcnt;
  logic [7:0]  next_pcnt;
  logic [7:0]  pace_lim;
  logic [15:0] next_rd_data;
  logic        next_done;
  logic        next_out;
  logic        next_oe_n;
  logic        ser_tick;
  logic        bus_tick;
  logic        tx_bit;
  sdbg_state_t after_tx;

  // ============================================================
  // Serial and bus clock rates
  sdbg_tick #(.DIV(SER_DIV)) u_ser_tick
  (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tick    (ser_tick)
  );

  sdbg_tick #(.DIV(BUS_DIV)) u_bus_tick
  (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tick    (bus_tick)
  );

  // ============================================================
  // Pacing allowance per command kind, covering target steal waits
  always_comb
  begin
    case (kind)
      SDBG_K_HW_RD: pace_lim = `SDBG_HW_RD_WAIT;
      SDBG_K_HW_WR: pace_lim = `SDBG_HW_WR_WAIT;
      SDBG_K_FW_RD: pace_lim = `SDBG_FW_RD_WAIT;
      SDBG_K_FW_WR: pace_lim = `SDBG_FW_WR_WAIT;
      SDBG_K_RUN:   pace_lim = `SDBG_RUN_WAIT;
      default:      pace_lim = 8'h00;
    endcase
  end

  assign tx_bit   = tx_sh[39];
  assign after_tx = use_ack ? SDBG_S_ACK_LO : SDBG_S_PACE;

  // ============================================================
  // Sequencer
  always_comb
  begin
    next_state   = state;
    next_kind    = kind;
    next_use_ack = use_ack;
    next_scyc    = scyc;
    next_bitn    = bitn;
    next_rxn     = rxn;
    next_tx_sh   = tx_sh;
    next_rx_sh   = rx_sh;
    next_pcnt    = pcnt;
    next_rd_data = rd_data;
    next_done    = 1'b0;
    case (state)
      SDBG_S_IDLE:
      begin
        if (cmd_valid && cmd_tx_bytes != 3'b000)
        begin
          next_state   = SDBG_S_TX_BIT;
          next_kind    = cmd_kind;
          next_use_ack = cmd_use_ack;
          next_tx_sh   = cmd_tx;
          next_bitn    = {cmd_tx_bytes, 3'b000};
          next_rxn     = {cmd_rx_bytes, 3'b000};
          next_scyc    = 8'h00;
        end
      end
      SDBG_S_TX_BIT:
      begin
        if (ser_tick)
        begin
          next_scyc = scyc + 8'h01;
          if (scyc == `SDBG_BIT_LAST)
          begin
            next_scyc  = 8'h00;
            next_tx_sh = {tx_sh[38:0], 1'b0};
            next_bitn  = bitn - 6'h01;
            next_pcnt  = 8'h00;
            if (bitn == 6'h01)
              next_state = after_tx;
          end
        end
      end
      SDBG_S_PACE:
      begin
        if (pcnt == pace_lim)
          next_state = (rxn != 5'h00) ? SDBG_S_RX_BIT : SDBG_S_IDLE;
        else if (bus_tick)
          next_pcnt = pcnt + 8'h01;
        if (pcnt == pace_lim && rxn == 5'h00)
          next_done = 1'b1;
      end
      SDBG_S_ACK_LO:
      begin
        // No time-out: only an abort leaves an unanswered wait
        if (!debug_serial_line_in)
          next_state = SDBG_S_ACK_HI;
      end
      SDBG_S_ACK_HI:
      begin
        if (debug_serial_line_in)
        begin
          next_state = (rxn != 5'h00) ? SDBG_S_RX_BIT : SDBG_S_IDLE;
          next_done  = (rxn == 5'h00);
        end
      end
      SDBG_S_RX_BIT:
      begin
        if (ser_tick)
        begin
          next_scyc = scyc + 8'h01;
          if (scyc == `SDBG_RX_SAMPLE)
            next_rx_sh = {rx_sh[14:0], debug_serial_line_in};
          if (scyc == `SDBG_BIT_LAST)
          begin
            next_scyc = 8'h00;
            next_rxn  = rxn - 5'h01;
            if (rxn == 5'h01)
            begin
              next_state   = SDBG_S_IDLE;
              next_done    = 1'b1;
              next_rd_data = rx_sh;
            end
          end
        end
      end
      SDBG_S_ABORT_LO:
      begin
        if (ser_tick)
        begin
          next_scyc = scyc + 8'h01;
          if (scyc == `SDBG_ABORT_LAST)
          begin
            next_scyc  = 8'h00;
            next_state = SDBG_S_ABORT_HI;
          end
        end
      end
      SDBG_S_ABORT_HI:
      begin
        if (ser_tick)
          next_state = SDBG_S_SYNC_LO;
      end
      SDBG_S_SYNC_LO:
      begin
        if (!debug_serial_line_in)
          next_state = SDBG_S_SYNC_HI;
      end
      SDBG_S_SYNC_HI:
      begin
        if (debug_serial_line_in)
          next_state = SDBG_S_IDLE;
      end
      default:
        next_state = SDBG_S_IDLE;
    endcase
    if (abort_req && state != SDBG_S_ABORT_LO && state != SDBG_S_ABORT_HI)
    begin
      next_state = SDBG_S_ABORT_LO;
      next_scyc  = 8'h00;
      next_done  = 1'b0;
    end
  end

  // ============================================================
  // Line drive: low phases and one-cycle speedup pulses only
  always_comb
  begin
    next_out  = 1'b0;
    next_oe_n = 1'b1;
    case (state)
      SDBG_S_TX_BIT:
      begin
        if (scyc < (tx_bit ? `SDBG_ONE_LOW : `SDBG_ZERO_LOW))
          next_oe_n = 1'b0;
        else if (scyc == (tx_bit ? `SDBG_ONE_LOW : `SDBG_ZERO_LOW))
        begin
          next_oe_n = 1'b0;
          next_out  = 1'b1;
        end
      end
      SDBG_S_RX_BIT:
      begin
        if (scyc < `SDBG_RX_LOW)
          next_oe_n = 1'b0;
        else if (scyc == `SDBG_RX_LOW)
        begin
          next_oe_n = 1'b0;
          next_out  = 1'b1;
        end
      end
      SDBG_S_ABORT_LO:
        next_oe_n = 1'b0;
      SDBG_S_ABORT_HI:
      begin
        next_oe_n = 1'b0;
        next_out  = 1'b1;
      end
      default:
        next_oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state                  <= SDBG_S_IDLE;
      kind                   <= SDBG_K_PLAIN;
      use_ack                <= 1'b0;
      scyc                   <= 8'h00;
      bitn                   <= 6'h00;
      rxn                    <= 5'h00;
      tx_sh                  <= 40'h0000000000;
      rx_sh                  <= 16'h0000;
      pcnt                   <= 8'h00;
      rd_data                <= 16'h0000;
      done                   <= 1'b0;
      cmd_ready              <= 1'b0;
      ack_wait               <= 1'b0;
      debug_serial_line_out  <= 1'b0;
      debug_serial_line_oe_n <= 1'b1;
    end
    else
    begin
      state                  <= next_state;
      kind                   <= next_kind;
      use_ack                <= next_use_ack;
      scyc                   <= next_scyc;
      bitn                   <= next_bitn;
      rxn                    <= next_rxn;
      tx_sh                  <= next_tx_sh;
      rx_sh                  <= next_rx_sh;
      pcnt                   <= next_pcnt;
      rd_data                <= next_rd_data;
      done                   <= next_done;
      cmd_ready              <= (next_state == SDBG_S_IDLE);
      ack_wait               <= (next_state == SDBG_S_ACK_LO);
      debug_serial_line_out  <= next_out;
      debug_serial_line_oe_n <= next_oe_n;
    end
  end

  // ============================================================
  // Checks
  logic [15:0] hi_run;
  always_ff @(posedge clk_sys)
  begin
    if (srst || debug_serial_line_oe_n || !debug_serial_line_out)
      hi_run <= 16'h0000;
    else
      hi_run <= hi_run + 16'h0001;
  end

  property p_hw_pace;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_PACE && next_state != SDBG_S_PACE && !abort_req
       && (kind == SDBG_K_HW_RD || kind == SDBG_K_HW_WR))
      |-> pcnt == 8'd150;
  endproperty
  a_hw_pace: assert property (p_hw_pace)
    else $error("hardware command paced other than 150 bus cycles");

  property p_fw_rd_pace;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_PACE && kind == SDBG_K_FW_RD && !abort_req)
      ##1 (state == SDBG_S_RX_BIT) |-> $past(pcnt) == 8'd48;
  endproperty
  a_fw_rd_pace: assert property (p_fw_rd_pace)
    else $error("firmware read data fetched before 48 bus cycles");

  property p_fw_wr_pace;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_PACE && kind == SDBG_K_FW_WR && !abort_req)
      ##1 (state == SDBG_S_IDLE) |-> $past(pcnt) == 8'd36;
  endproperty
  a_fw_wr_pace: assert property (p_fw_wr_pace)
    else $error("firmware write not paced 36 bus cycles");

  property p_run_pace;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_PACE && kind == SDBG_K_RUN && pcnt < 8'd76)
      |=> (state == SDBG_S_PACE || state == SDBG_S_ABORT_LO);
  endproperty
  a_run_pace: assert property (p_run_pace)
    else $error("left run pacing before 76 bus cycles");

  property p_ack_no_pace;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_PACE) |-> !use_ack;
  endproperty
  a_ack_no_pace: assert property (p_ack_no_pace)
    else $error("fixed pacing used in acknowledge mode");

  property p_bit_falls;
    @(posedge clk_sys) disable iff (srst)
      $fell(debug_serial_line_oe_n) |-> !debug_serial_line_out;
  endproperty
  a_bit_falls: assert property (p_bit_falls)
    else $error("drive began without a falling edge");

  property p_speedup_brief;
    @(posedge clk_sys) disable iff (srst)
      (!debug_serial_line_oe_n && debug_serial_line_out)
      |-> hi_run < 16'(SER_DIV + 1);
  endproperty
  a_speedup_brief: assert property (p_speedup_brief)
    else $error("line driven high longer than a speedup pulse");

  property p_no_cmd_in_ack;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_ACK_LO) |=> !cmd_ready;
  endproperty
  a_no_cmd_in_ack: assert property (p_no_cmd_in_ack)
    else $error("command offered while acknowledge outstanding");

  property p_abort_len;
    @(posedge clk_sys) disable iff (srst)
      (state == SDBG_S_ABORT_LO) ##1 (state == SDBG_S_ABORT_HI)
      |-> $past(scyc) == 8'd127;
  endproperty
  a_abort_len: assert property (p_abort_len)
    else $error("abort low shorter than 128 serial cycles");
endmodule

// *** sdbg_target.sv ***
// Behavioural debug target that sits on the far end of the serial line.
// Assumes the bench resolves the open-drain line and pulses arm per command.
`timescale 1ns/1ps
module sdbg_target
#(
  parameter int SER_DIV = 2,
  parameter int ACK_DLY = 40
)
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        arm,
  input  wire logic        line,
  input  wire logic [5:0]  exp_bits,
  input  wire logic [4:0]  rd_bits,
  input  wire logic        ack_en,
  input  wire logic        discard,
  input  wire logic [15:0] rd_val,
  input  wire logic [15:0] lat,
  output logic             tgt_out,
  output logic             tgt_oe_n,
  output logic [39:0]      got_cmd,
  output logic [5:0]       got_n,
  output int               n_ack,
  output int               n_sync
);
  int         lo_cnt;
  int         drv_lo;
  int         drv_hi;
  int         dly;
  int         busy;
  logic       line_q;
  logic       own;
  logic [1:0] mode;
  logic [4:0] rx_i;
  logic       rise;
  logic       fall;

  assign rise = line & ~line_q;
  assign fall = ~line & line_q & tgt_oe_n;

  // ============================================================
  // Line drive and decode
  always_ff @(posedge clk_sys)
  begin
    line_q <= line;
    lo_cnt <= line ? 0 : lo_cnt + 1;
    if (busy > 0)
      busy <= busy - 1;
    if (drv_lo > 0)
      own <= 1'b1;
    else if (rise)
      own <= 1'b0;
    if (drv_lo > 0)
    begin
      tgt_oe_n <= 1'b0;
      tgt_out  <= 1'b0;
      drv_lo   <= drv_lo - 1;
      drv_hi   <= (drv_lo == 1) ? SER_DIV : 0;
    end
    else if (drv_hi > 0)
    begin
      tgt_out <= 1'b1;
      drv_hi  <= drv_hi - 1;
    end
    else
      tgt_oe_n <= 1'b1;
    if (srst || arm)
    begin
      mode    <= 2'h0;
      got_n   <= 6'h00;
      got_cmd <= 40'h0;
      rx_i    <= 5'h00;
      busy    <= 0;
    end
    if (srst)
    begin
      drv_lo   <= 0;
      drv_hi   <= 0;
      n_ack    <= 0;
      n_sync   <= 0;
      own      <= 1'b0;
      tgt_oe_n <= 1'b1;
      tgt_out  <= 1'b1;
    end
    else if (rise && !own && lo_cnt >= 64 * SER_DIV)
    begin
      // Long host low kills the pending command and its acknowledge
      mode   <= 2'h3;
      drv_lo <= 16 * SER_DIV;
      n_sync <= n_sync + 1;
    end
    else if (rise && !own && mode == 2'h0)
    begin
      got_cmd <= {got_cmd[38:0], lo_cnt < 8 * SER_DIV};
      got_n   <= got_n + 6'h01;
      dly     <= ACK_DLY;
      if (got_n + 6'h01 == exp_bits)
      begin
        // Steal wait and stretch run in the background; no external wait
        busy <= lat;
        mode <= discard ? 2'h3 : ack_en ? 2'h1 : 2'h2;
      end
    end
    else if (mode == 2'h1 && busy == 0)
    begin
      // Acknowledge only once the access has finished
      dly <= dly - 1;
      if (dly == 0)
      begin
        drv_lo <= 16 * SER_DIV;
        n_ack  <= n_ack + 1;
        mode   <= 2'h2;
      end
    end
    else if (mode == 2'h2 && fall && rx_i < rd_bits)
    begin
      // Data fetched before the access ends comes back inverted
      if (rd_val[rd_bits - rx_i - 5'h01] == (busy > 0))
        drv_lo <= 12 * SER_DIV;
      rx_i <= rx_i + 5'h01;
    end
  end
endmodule

// *** sdbg_host_tb_top.sv ***
// Self-checking bench for the single-wire debug host.
// Assumes sdbg_target stands in for the device on the line.
`timescale 1ns/1ps
module sdbg_host_tb_top
  import sdbg_pkg::*;
;
  localparam int SER_DIV = 2;
  localparam int BUS_DIV = 3;
  localparam int ACK_DLY = 40;

  logic        clk_sys;
  logic        srst;
  logic        cmd_valid;
  sdbg_kind_t  cmd_kind;
  logic        cmd_use_ack;
  logic [39:0] cmd_tx;
  logic [2:0]  cmd_tx_bytes;
  logic [1:0]  cmd_rx_bytes;
  logic        abort_req;
  logic        cmd_ready;
  logic        done;
  logic [15:0] rd_data;
  logic        ack_wait;
  logic        line;
  logic        h_out;
  logic        h_oe_n;
  logic        arm;
  logic [5:0]  exp_bits;
  logic [4:0]  rd_bits;
  logic        ack_en;
  logic        discard;
  logic [15:0] rd_val;
  logic [15:0] lat;
  logic        tgt_out;
  logic        tgt_oe_n;
  logic [39:0] got_cmd;
  logic [5:0]  got_n;
  int          n_ack;
  int          n_sync;
  int          num_errors;
  int          total_checks;
  int          lo_run = 0;
  int          last_run = 0;

  // Open-drain line with pull-up
  assign line = (h_oe_n | h_out) & (tgt_oe_n | tgt_out);

  sdbg_host #(.SER_DIV(SER_DIV), .BUS_DIV(BUS_DIV)) uut (
    .clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_use_ack(cmd_use_ack), .cmd_tx(cmd_tx),
    .cmd_tx_bytes(cmd_tx_bytes), .cmd_rx_bytes(cmd_rx_bytes),
    .abort_req(abort_req), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .ack_wait(ack_wait), .debug_serial_line_in(line),
    .debug_serial_line_out(h_out), .debug_serial_line_oe_n(h_oe_n));

  sdbg_target #(.SER_DIV(SER_DIV), .ACK_DLY(ACK_DLY)) target (
    .clk_sys(clk_sys), .srst(srst), .arm(arm), .line(line),
    .exp_bits(exp_bits), .rd_bits(rd_bits), .ack_en(ack_en),
    .discard(discard), .rd_val(rd_val), .lat(lat), .tgt_out(tgt_out),
    .tgt_oe_n(tgt_oe_n), .got_cmd(got_cmd), .got_n(got_n),
    .n_ack(n_ack), .n_sync(n_sync));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (!h_oe_n && !h_out)
      lo_run <= lo_run + 1;
    else if (lo_run > 0)
    begin
      last_run <= lo_run;
      lo_run   <= 0;
    end
  end

  // ============================================================
  // Checks and helpers
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp,
                         input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_true(input logic ok, input string what);
    chk_val({39'h0, ok}, 40'h1, what);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic run_cmd(input sdbg_kind_t k, input logic ack,
                         input logic [39:0] tx, input logic [2:0] txb,
                         input logic [1:0] rxb, input int pace,
                         input logic disc);
    int          n;
    int          lo;
    logic        saw;
    logic        ok;
    logic [15:0] msk;
    cmd_kind     = k;
    cmd_use_ack  = ack;
    cmd_tx       = tx;
    cmd_tx_bytes = txb;
    cmd_rx_bytes = rxb;
    exp_bits     = 6'(txb * 8);
    rd_bits      = 5'(rxb * 8);
    ack_en       = ack;
    discard      = disc;
    rd_val       = 16'h5a3c ^ {tx[31:17], 1'b0};
    lat          = 16'h0000;
    if (rxb != 2'h0)
      lat = 16'((pace - 1) * BUS_DIV);
    cmd_valid    = 1'b1;
    arm          = 1'b1;
    tick();
    cmd_valid = 1'b0;
    arm       = 1'b0;
    for (n = 0; got_n != exp_bits && n < 9000; n++)
      tick();
    chk_val(got_cmd, tx >> (40 - 8 * txb), "frame");
    if (disc)
      return;
    saw = 1'b0;
    for (n = 0; !done && (h_oe_n || h_out) && n < 4000; n++)
    begin
      saw = saw | ack_wait;
      tick();
    end
    lo = ack ? lat + ACK_DLY : pace * BUS_DIV;
    ok = n >= lo - BUS_DIV && n <= lo + 40 * SER_DIV + 8 * BUS_DIV;
    chk_true(ok, "pacing");
    chk_true(saw === ack, "ack wait");
    for (n = 0; !done && n < 9000; n++)
      tick();
    chk_true(done, "done");
    msk = (rxb == 2'h2) ? 16'hffff : (rxb == 2'h1) ? 16'h00ff : 16'h0;
    chk_val({24'h0, rd_data & msk}, {24'h0, rd_val & msk}, "rdata");
    $display("test kind %0d ack %0d finished", k, ack);
  endtask

  task automatic t_abort;
    int   n;
    int   na;
    logic bad;
    logic ok;
    na = n_ack;
    run_cmd(SDBG_K_FW_WR, 1'b1, 40'h44_3c00_0000, 3'h2, 2'h0, 36, 1'b1);
    repeat (100) tick();
    bad = 1'b0;
    for (n = 0; n < 2000; n++)
    begin
      bad = bad | done | cmd_ready | ~ack_wait;
      tick();
    end
    chk_true(!bad, "held waiting");
    chk_true(n_ack == na, "no ack");
    abort_req = 1'b1;
    tick();
    abort_req = 1'b0;
    for (n = 0; (h_oe_n || !h_out) && n < 2000; n++)
      tick();
    tick();
    ok = last_run >= 127 * SER_DIV + 1 && last_run <= 129 * SER_DIV;
    chk_true(ok, "abort low");
    for (n = 0; !cmd_ready && n < 2000; n++)
      tick();
    chk_true(cmd_ready && n_sync == 1, "resync");
    run_cmd(SDBG_K_PLAIN, 1'b0, 40'h9c_0000_0000, 3'h1, 2'h0, 0, 1'b0);
    $display("test abort finished");
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    num_errors   = 0;
    total_checks = 0;
    srst         = 1'b1;
    cmd_valid    = 1'b0;
    cmd_kind     = SDBG_K_PLAIN;
    cmd_use_ack  = 1'b0;
    cmd_tx       = 40'h0;
    cmd_tx_bytes = 3'h0;
    cmd_rx_bytes = 2'h0;
    abort_req    = 1'b0;
    arm          = 1'b0;
    exp_bits     = 6'h00;
    rd_bits      = 5'h00;
    ack_en       = 1'b0;
    discard      = 1'b0;
    rd_val       = 16'h0;
    lat          = 16'h0000;
    repeat (6) tick();
    chk_true(!cmd_ready && h_oe_n && !done, "in reset");
    srst = 1'b0;
    tick();
    tick();
    chk_true(cmd_ready, "ready");
    // A request with no bytes must be ignored
    cmd_valid = 1'b1;
    tick();
    tick();
    cmd_valid = 1'b0;
    chk_true(cmd_ready && h_oe_n, "empty request");
    run_cmd(SDBG_K_HW_RD, 1'b0, 40'he8_1235_0000, 3'h3, 2'h2, 150, 1'b0);
    run_cmd(SDBG_K_HW_WR, 1'b0, 40'hc8_2001_beef, 3'h5, 2'h0, 150, 1'b0);
    run_cmd(SDBG_K_FW_RD, 1'b0, 40'h64_0000_0000, 3'h1, 2'h1, 48, 1'b0);
    run_cmd(SDBG_K_FW_WR, 1'b0, 40'h44_a500_0000, 3'h2, 2'h0, 36, 1'b0);
    run_cmd(SDBG_K_RUN, 1'b0, 40'h08_0000_0000, 3'h1, 2'h0, 76, 1'b0);
    run_cmd(SDBG_K_PLAIN, 1'b0, 40'hd8_0000_0000, 3'h1, 2'h0, 0, 1'b0);
    run_cmd(SDBG_K_HW_RD, 1'b1, 40'he8_0102_0000, 3'h3, 2'h1, 150, 1'b0);
    t_abort();
    tally_and_finish();
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
